// ==== rtl/dmd_pkg.sv ====
// Constants for the dual-modulus divider chain: register offsets,
// programming word layout, reset values and prescaler terminals.
// Assumes a single 100 MHz system clock.

package dmd_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int DMD_ADDR_W = 4;
   localparam int DMD_DATA_W = 32;
   localparam logic [3:0] DMD_OFS_PROG = 4'h0;
   localparam logic [3:0] DMD_OFS_EFF = 4'h4;
   localparam logic [3:0] DMD_OFS_STAT = 4'h8;

   // ****************************************************************
   // Programming word layout
   // ****************************************************************
   localparam int DMD_PROG_W = 20;
   localparam logic [19:0] DMD_PROG_RST = 20'h0_0000;
   localparam int DMD_A_LSB = 0;
   localparam int DMD_A_MSB = 3;
   localparam int DMD_R_LO_LSB = 4;
   localparam int DMD_R_LO_MSB = 7;
   localparam int DMD_M_LO_LSB = 8;
   localparam int DMD_M_LO_MSB = 14;
   localparam int DMD_PRE_BYP_BIT = 15;
   localparam int DMD_M_HI_LSB = 16;
   localparam int DMD_M_HI_MSB = 17;
   localparam int DMD_R_HI_LSB = 18;
   localparam int DMD_R_HI_MSB = 19;

   // ****************************************************************
   // Counter widths and prescaler terminals
   // ****************************************************************
   localparam int DMD_M_W = 9;
   localparam int DMD_R_W = 6;
   localparam int DMD_A_W = 4;
   localparam int DMD_PSC_W = 4;
   localparam logic [3:0] DMD_PSC_TERM_TEN = 4'h9;
   localparam logic [3:0] DMD_PSC_TERM_ELEVEN = 4'hA;
   localparam logic [3:0] DMD_PSC_RST = 4'h0;
   localparam logic [15:0] DMD_PSC_BASE = 16'h000A;

   // ****************************************************************
   // Status word layout
   // ****************************************************************
   localparam int DMD_ST_UP = 0;
   localparam int DMD_ST_DN = 1;
   localparam int DMD_ST_FP = 2;
   localparam int DMD_ST_FC = 3;
   localparam int DMD_ST_MSEL = 4;
   localparam int DMD_ST_PDN = 5;
   localparam int DMD_ST_DIR = 6;
   localparam int DMD_ST_A_LSB = 8;
   localparam int DMD_ST_M_LSB = 16;

   typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DN} dmd_pfd_t;

endpackage

// ==== rtl/dmd_reload_cnt.sv ====
// Down counter that reloads its programmed value at zero.
// Assumes tick_i is a one-cycle enable in the system clock domain.
`timescale 1ns/10ps
`default_nettype none

module dmd_reload_cnt #(
   parameter int W = 9
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic [W-1:0] load_i,
   output logic [W-1:0] cnt_o,
   output logic wrap_o
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // ****************************************************************
   // Count down, reload at terminal count
   // ****************************************************************
   always_comb
   begin
      cnt_d = cnt_q;
      wrap_o = 1'b0;
      if (tick_i)
      begin
         if (cnt_q == '0)
         begin
            cnt_d = load_i;
            wrap_o = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign cnt_o = cnt_q;

endmodule

`default_nettype wire

// ==== rtl/dmd_divider_chain.sv ====
// Integer-N divider chain: 10/11 prescaler, swallow and main counters,
// reference counter and phase-frequency detector, with a register port.
// Assumes RF and reference edges arrive as one-cycle pulses on sys_clk_i.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module dmd_divider_chain (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rf_pulse_i,
   input wire logic ref_pulse_i,
   input wire logic dir_mode_i,
   input wire logic dir_pre_byp_i,
   input wire logic [6:0] dir_main_i,
   input wire logic [3:0] dir_ref_i,
   input wire logic [3:0] dir_swallow_i,
   input wire logic [dmd_pkg::DMD_ADDR_W-1:0] addr_i,
   input wire logic [dmd_pkg::DMD_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [dmd_pkg::DMD_DATA_W-1:0] rdata_o,
   output logic fp_o,
   output logic fc_o,
   output logic pd_up_o,
   output logic pd_dn_o,
   output logic msel_o,
   output logic pre_pwr_dn_o
);
   import dmd_pkg::*;

   // ****************************************************************
   // Programming register and effective word
   // ****************************************************************
   logic [DMD_PROG_W-1:0] prog_q;
   logic [DMD_PROG_W-1:0] prog_d;
   logic [DMD_PROG_W-1:0] eff_word;
   logic [DMD_M_W-1:0] eff_main;
   logic [DMD_R_W-1:0] eff_ref;
   logic [DMD_A_W-1:0] eff_swallow;
   logic eff_byp;

   always_comb
   begin
      prog_d = prog_q;
      if (wr_i && (addr_i == DMD_OFS_PROG))
         prog_d = wdata_i[DMD_PROG_W-1:0];
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prog_q <= DMD_PROG_RST;
      else
         prog_q <= prog_d;
   end

   // Direct mode takes the pins, upper bits forced low
   always_comb
   begin
      if (dir_mode_i)
      begin
         eff_word = '0;
         eff_word[DMD_A_MSB:DMD_A_LSB] = dir_swallow_i;
         eff_word[DMD_R_LO_MSB:DMD_R_LO_LSB] = dir_ref_i;
         eff_word[DMD_M_LO_MSB:DMD_M_LO_LSB] = dir_main_i;
         eff_word[DMD_PRE_BYP_BIT] = dir_pre_byp_i;
      end
      else
      begin
         eff_word = prog_q;
      end
   end

   assign eff_swallow = eff_word[DMD_A_MSB:DMD_A_LSB];
   assign eff_ref = {eff_word[DMD_R_HI_MSB:DMD_R_HI_LSB], eff_word[DMD_R_LO_MSB:DMD_R_LO_LSB]};
   assign eff_main = {eff_word[DMD_M_HI_MSB:DMD_M_HI_LSB], eff_word[DMD_M_LO_MSB:DMD_M_LO_LSB]};
   assign eff_byp = eff_word[DMD_PRE_BYP_BIT];

   // ****************************************************************
   // Prescaler and swallow counter
   // ****************************************************************
   logic [DMD_PSC_W-1:0] psc_q;
   logic [DMD_PSC_W-1:0] psc_d;
   logic [DMD_A_W-1:0] swl_q;
   logic [DMD_A_W-1:0] swl_d;
   logic msel;
   logic pre_tick;
   logic m_wrap;
   logic r_wrap;
   logic [DMD_M_W-1:0] m_cnt;
   logic [DMD_R_W-1:0] r_cnt;
   logic [DMD_PSC_W-1:0] psc_term;
   assign msel = (swl_q != '0);
   assign psc_term = msel ? DMD_PSC_TERM_ELEVEN : DMD_PSC_TERM_TEN;

   always_comb
   begin
      psc_d = psc_q;
      pre_tick = 1'b0;
      if (eff_byp)
      begin
         psc_d = DMD_PSC_RST;
         pre_tick = rf_pulse_i;
      end
      else if (rf_pulse_i)
      begin
         if (psc_q >= psc_term)
         begin
            psc_d = DMD_PSC_RST;
            pre_tick = 1'b1;
         end
         else
         begin
            psc_d = psc_q + 1'b1;
         end
      end
   end

   always_comb
   begin
      swl_d = swl_q;
      if (m_wrap)
         swl_d = eff_swallow;
      else if (pre_tick && msel)
         swl_d = swl_q - 1'b1;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         psc_q <= DMD_PSC_RST;
         swl_q <= '0;
      end
      else
      begin
         psc_q <= psc_d;
         swl_q <= swl_d;
      end
   end

   // ****************************************************************
   // Main and reference counters
   // ****************************************************************
   dmd_reload_cnt #(.W(DMD_M_W)) u_main_cnt (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(pre_tick),
      .load_i(eff_main),
      .cnt_o(m_cnt),
      .wrap_o(m_wrap)
   );

   dmd_reload_cnt #(.W(DMD_R_W)) u_ref_cnt (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(ref_pulse_i),
      .load_i(eff_ref),
      .cnt_o(r_cnt),
      .wrap_o(r_wrap)
   );

   // ****************************************************************
   // Phase-frequency detector
   // ****************************************************************
   dmd_pfd_t pfd_q;
   dmd_pfd_t pfd_d;

   always_comb
   begin
      pfd_d = pfd_q;
      case (pfd_q)
         PFD_IDLE:
            if (fc_o && !fp_o)
               pfd_d = PFD_UP;
            else if (fp_o && !fc_o)
               pfd_d = PFD_DN;
         PFD_UP:
            if (fp_o)
               pfd_d = PFD_IDLE;
         PFD_DN:
            if (fc_o)
               pfd_d = PFD_IDLE;
         default:
            pfd_d = PFD_IDLE;
      endcase
   end

   // ****************************************************************
   // Registered outputs and read port
   // ****************************************************************
   logic [DMD_DATA_W-1:0] rdata_d;
   logic [DMD_DATA_W-1:0] status;

   always_comb
   begin
      status = '0;
      status[DMD_ST_UP] = pd_up_o;
      status[DMD_ST_DN] = pd_dn_o;
      status[DMD_ST_FP] = fp_o;
      status[DMD_ST_FC] = fc_o;
      status[DMD_ST_MSEL] = msel_o;
      status[DMD_ST_PDN] = pre_pwr_dn_o;
      status[DMD_ST_DIR] = dir_mode_i;
      status[DMD_ST_A_LSB +: DMD_A_W] = swl_q;
      status[DMD_ST_M_LSB +: DMD_M_W] = m_cnt;
   end

   always_comb
   begin
      rdata_d = '0;
      if (rd_i)
      begin
         if (addr_i == DMD_OFS_PROG)
            rdata_d = {12'h000, prog_q};
         else if (addr_i == DMD_OFS_EFF)
            rdata_d = {12'h000, eff_word};
         else if (addr_i == DMD_OFS_STAT)
            rdata_d = status;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pfd_q <= PFD_IDLE;
         rdata_o <= '0;
         fp_o <= 1'b0;
         fc_o <= 1'b0;
         pd_up_o <= 1'b0;
         pd_dn_o <= 1'b0;
         msel_o <= 1'b0;
         pre_pwr_dn_o <= 1'b0;
      end
      else
      begin
         pfd_q <= pfd_d;
         rdata_o <= rdata_d;
         fp_o <= m_wrap;
         fc_o <= r_wrap;
         pd_up_o <= (pfd_d == PFD_UP);
         pd_dn_o <= (pfd_d == PFD_DN);
         msel_o <= msel;
         pre_pwr_dn_o <= eff_byp;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [15:0] rf_cnt_q;
   logic [1:0] settle_q;
   logic [DMD_PROG_W-1:0] eff_prev_q;
   logic [15:0] expect_div;

   assign expect_div = ({7'h00, eff_main} + 16'h0001) * DMD_PSC_BASE + {12'h000, eff_swallow};

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rf_cnt_q <= '0;
         settle_q <= '0;
         eff_prev_q <= DMD_PROG_RST;
      end
      else
      begin
         eff_prev_q <= eff_word;
         if (m_wrap)
            rf_cnt_q <= '0;
         else if (rf_pulse_i)
            rf_cnt_q <= rf_cnt_q + 16'h0001;
         if (eff_word != eff_prev_q)
            settle_q <= '0;
         else if (m_wrap && (settle_q != 2'h3))
            settle_q <= settle_q + 2'h1;
      end
   end

   property p_psc_range;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      psc_q <= DMD_PSC_TERM_ELEVEN;
   endproperty
   a_psc_range: assert property (p_psc_range) else $error("prescaler count out of range");

   property p_psc_path;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!eff_byp && rf_pulse_i && psc_q == psc_term) |-> pre_tick && psc_d == DMD_PSC_RST;
   endproperty
   a_psc_path: assert property (p_psc_path) else $error("prescaler terminal missed");

   property p_bypass;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      eff_byp |-> (pre_tick == rf_pulse_i) ##1 (psc_q == DMD_PSC_RST && pre_pwr_dn_o);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass path wrong");

   sequence s_settled_wrap;
      m_wrap && settle_q == 2'h3 && !eff_byp && eff_main != '0;
   endsequence

   property p_main_ratio;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_settled_wrap and ({12'h000, eff_swallow} <= {7'h00, eff_main} + 16'h0001)
      |-> (rf_cnt_q + 16'h0001) == expect_div;
   endproperty
   a_main_ratio: assert property (p_main_ratio) else $error("main chain ratio wrong");

   property p_main_two;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (pre_tick && m_cnt == 9'h001 && eff_main == 9'h001) |=> (m_cnt == 9'h000) ##0 !fp_o;
   endproperty
   a_main_two: assert property (p_main_two) else $error("main count of one not two");

   property p_ref_pass;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ref_pulse_i && eff_ref == 6'h00 && r_cnt == 6'h00) |=> fc_o && r_cnt == 6'h00;
   endproperty
   a_ref_pass: assert property (p_ref_pass) else $error("reference pass-through lost");

   property p_direct_force;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      dir_mode_i |-> eff_main[8:7] == 2'h0 && eff_ref[5:4] == 2'h0;
   endproperty
   a_direct_force: assert property (p_direct_force) else $error("direct mode bits not forced");

   property p_prog_write;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == DMD_OFS_PROG) |=> prog_q == $past(wdata_i[DMD_PROG_W-1:0]);
   endproperty
   a_prog_write: assert property (p_prog_write) else $error("programming word not stored");

   property p_pfd_up;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (fc_o && !fp_o && !pd_dn_o) |=> pd_up_o && !pd_dn_o;
   endproperty
   a_pfd_up: assert property (p_pfd_up) else $error("up pulse not raised");

   property p_msel;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (swl_q != 4'h0) |=> msel_o;
   endproperty
   a_msel: assert property (p_msel) else $error("modulus select not eleven");

endmodule

`default_nettype wire

// ==== dv/dmd_osc_model.sv ====
// Behavioural stand-in for the VCO and the reference oscillator.
// Assumes both edge streams are one-cycle pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none

module dmd_osc_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] rf_div_i,
   input wire logic [7:0] ref_div_i,
   output logic rf_pulse_o,
   output logic ref_pulse_o
);
   logic [7:0] rf_cnt_q;
   logic [7:0] ref_cnt_q;

   // ************************************************
   // Edge pacing, one pulse every div cycles
   // ************************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rf_cnt_q <= 8'h00;
         ref_cnt_q <= 8'h00;
         rf_pulse_o <= 1'b0;
         ref_pulse_o <= 1'b0;
      end
      else
      begin
         // Bench keeps RF pacing well above comparison rate
         rf_pulse_o <= (rf_cnt_q == 8'h00);
         rf_cnt_q <= (rf_cnt_q == 8'h00) ? rf_div_i - 8'h01 : rf_cnt_q - 8'h01;
         ref_pulse_o <= (ref_cnt_q == 8'h00);
         ref_cnt_q <= (ref_cnt_q == 8'h00) ? ref_div_i - 8'h01 : ref_cnt_q - 8'h01;
      end
   end
endmodule

`default_nettype wire

// ==== dv/dmd_divider_chain_tb.sv ====
// Self-checking bench for the divider chain: register port, division ratios,
// modulus select share, direct mode forcing and phase detector direction.
// Assumes the oscillator model in dmd_osc_model.sv.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, a); end end

module dmd_divider_chain_tb;
   import dmd_pkg::*;

   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] rf_div = 8'h01;
   logic [7:0] ref_div = 8'h01;
   logic rf_pulse, ref_pulse;
   logic dir_mode_i = 1'b0;
   logic dir_pre_byp_i = 1'b0;
   logic [6:0] dir_main_i = 7'h00;
   logic [3:0] dir_ref_i = 4'h0;
   logic [3:0] dir_swallow_i = 4'h0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic fp_o, fc_o, pd_up_o, pd_dn_o, msel_o, pre_pwr_dn_o;
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [31:0] d;
   int per, mhi, upc, dnc, both;

   always #5 sys_clk_i = ~sys_clk_i;

   dmd_osc_model u_dmd_osc_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .rf_div_i(rf_div), .ref_div_i(ref_div), .rf_pulse_o(rf_pulse), .ref_pulse_o(ref_pulse));

   dmd_divider_chain u_dmd_divider_chain (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .rf_pulse_i(rf_pulse), .ref_pulse_i(ref_pulse), .dir_mode_i(dir_mode_i),
      .dir_pre_byp_i(dir_pre_byp_i), .dir_main_i(dir_main_i), .dir_ref_i(dir_ref_i),
      .dir_swallow_i(dir_swallow_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .fp_o(fp_o), .fc_o(fc_o), .pd_up_o(pd_up_o),
      .pd_dn_o(pd_dn_o), .msel_o(msel_o), .pre_pwr_dn_o(pre_pwr_dn_o));

   // ************************************************
   // Bus and measurement tasks
   // ************************************************
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      v = rdata_o;
   endtask

   function automatic logic [19:0] word(input logic [8:0] m, input logic [5:0] r,
                                        input logic [3:0] a, input logic byp);
      return {r[5:4], m[8:7], byp, m[6:0], r[3:0], a};
   endfunction

   // Settle two periods, then count one full period of fp_o or fc_o
   task automatic measure(input bit sel, output int p, output int mh);
      int n;
      repeat (3)
      begin
         n = 0;
         mh = 0;
         do
         begin
            @(negedge sys_clk_i);
            n++;
            if (msel_o === 1'b1) mh++;
         end while ((sel ? fc_o : fp_o) !== 1'b1 && n < 5000);
      end
      p = n;
   endtask

   task automatic main_case(input int m, input int a, input bit byp, input int rfd);
      int exp;
      rf_div <= 8'(rfd);
      reg_wr(DMD_OFS_PROG, {12'h000, word(9'(m), 6'd5, 4'(a), byp)});
      exp = byp ? (m + 1) * rfd : (10 * (m + 1) + a) * rfd;
      measure(1'b0, per, mhi);
      `CHK("fp_period", exp, per)
      `CHK("pre_pwr_dn", byp, pre_pwr_dn_o)
      if (!byp && rfd == 1) `CHK("msel_cycles", 11 * a, mhi)
   endtask

   task automatic pfd_run();
      upc = 0;
      dnc = 0;
      both = 0;
      repeat (400)
      begin
         @(negedge sys_clk_i);
         if (pd_up_o === 1'b1) upc++;
         if (pd_dn_o === 1'b1) dnc++;
         if (pd_up_o === 1'b1 && pd_dn_o === 1'b1) both++;
      end
      `CHK("pfd_both", 0, both)
   endtask

   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         mismatches++;
         $display("ERROR timeout expected done seen running");
         test_done();
      end
   end

   // ************************************************
   // Test sequence
   // ************************************************
   initial
   begin
      repeat (5) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      reg_rd(DMD_OFS_PROG, d);
      `CHK("prog_reset", {12'h000, DMD_PROG_RST}, d)
      reg_rd(4'hC, d);
      `CHK("unmapped", 32'h0000_0000, d)
      reg_wr(DMD_OFS_PROG, 32'hFFFF_FFFF);
      reg_wr(DMD_OFS_EFF, 32'h0000_0000);
      reg_rd(DMD_OFS_PROG, d);
      `CHK("prog_width", 32'h000F_FFFF, d)
      main_case(1, 0, 1'b0, 1);
      main_case(1, 0, 1'b0, 3);
      main_case(3, 4, 1'b0, 1);
      main_case(2, 3, 1'b0, 1);
      main_case(384, 5, 1'b0, 1);
      main_case(5, 0, 1'b1, 1);
      rf_div <= 8'h01;
      for (int i = 0; i < 3; i++)
      begin
         reg_wr(DMD_OFS_PROG, {12'h000, word(9'd1, i == 0 ? 6'd0 : i == 1 ? 6'd5 : 6'd63,
                                            4'h0, 1'b0)});
         measure(1'b1, per, mhi);
         `CHK("fc_period", i == 0 ? 1 : i == 1 ? 6 : 64, per)
      end
      reg_wr(DMD_OFS_PROG, {12'h000, word(9'd1, 6'd6, 4'h0, 1'b0)});
      pfd_run();
      `CHK("pfd_up_seen", 1'b1, upc > dnc)
      reg_wr(DMD_OFS_PROG, {12'h000, word(9'd1, 6'd63, 4'h0, 1'b0)});
      pfd_run();
      `CHK("pfd_dn_seen", 1'b1, dnc > upc)
      reg_wr(DMD_OFS_PROG, {12'h000, word(9'd384, 6'd48, 4'h3, 1'b0)});
      @(posedge sys_clk_i);
      dir_mode_i <= 1'b1;
      dir_main_i <= 7'd4;
      dir_ref_i <= 4'd2;
      dir_swallow_i <= 4'd5;
      reg_rd(DMD_OFS_EFF, d);
      `CHK("eff_direct", {12'h000, word(9'd4, 6'd2, 4'd5, 1'b0)}, d)
      measure(1'b0, per, mhi);
      `CHK("fp_direct", 55, per)
      measure(1'b1, per, mhi);
      `CHK("fc_direct", 3, per)
      @(posedge sys_clk_i);
      dir_pre_byp_i <= 1'b1;
      measure(1'b0, per, mhi);
      `CHK("fp_dir_byp", 5, per)
      `CHK("pwr_dn_dir", 1'b1, pre_pwr_dn_o)
      reg_rd(DMD_OFS_STAT, d);
      `CHK("stat_dir", 1'b1, d[DMD_ST_DIR])
      test_done();
   end
endmodule

`default_nettype wire
